// ==== rtl/bfme_pkg.sv ====
// constants, field layouts and encodings of the bit, flag and move executor
// assumes an apb master on the core clock and a one-cycle data/io bus
// Behaviour
// - io bit set forces bit, two cycles
// - io bit clear forces bit, two cycles
// - rotate left through carry, flags, one cycle
// - rotate right through carry, flags, one cycle
// - bit to transfer flag, one cycle
// - transfer flag to register bit, one cycle
// - set or clear any single flag, one cycle
// - post-increment pointer load, two cycles, no flags
// - pre-decrement pointer load, two cycles, no flags
package bfme_pkg;
	localparam logic [7:0] BFME_OFF_CMD = 8'h00;
	localparam logic [7:0] BFME_OFF_STATUS = 8'h04;
	localparam logic [7:0] BFME_OFF_FLAGS = 8'h08;
	localparam logic [7:0] BFME_OFF_RESULT = 8'h0c;

	localparam int unsigned BFME_CMD_OP_LSB = 0;
	localparam int unsigned BFME_CMD_RD_LSB = 5;
	localparam int unsigned BFME_CMD_RR_LSB = 10;
	localparam int unsigned BFME_CMD_BIT_LSB = 15;
	localparam int unsigned BFME_CMD_IMM_LSB = 18;
	localparam int unsigned BFME_STAT_BUSY = 0;
	localparam int unsigned BFME_STAT_FLAGS_LSB = 8;

	// status flag bit positions
	localparam logic [2:0] BFME_FLAG_C = 3'h0;
	localparam logic [2:0] BFME_FLAG_Z = 3'h1;
	localparam logic [2:0] BFME_FLAG_N = 3'h2;
	localparam logic [2:0] BFME_FLAG_V = 3'h3;
	localparam logic [2:0] BFME_FLAG_T = 3'h6;
	localparam logic [7:0] BFME_FLAGS_RST = 8'h00;
	localparam logic [31:0] BFME_CMD_RST = 32'h0000_0000;

	// pointer pairs sit at the top of the file: pair index {2'b11, sel}
	localparam logic [1:0] BFME_PTR_BASE = 2'h3;
	localparam logic [1:0] BFME_CYC_ONE = 2'h1;
	localparam logic [1:0] BFME_CYC_TWO = 2'h2;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_IO_BIT_SET = 5'h01,
		OP_IO_BIT_CLEAR = 5'h02,
		OP_SHIFT_LEFT_LOGICAL = 5'h03,
		OP_SHIFT_RIGHT_LOGICAL = 5'h04,
		OP_ROTATE_LEFT_CARRY = 5'h05,
		OP_ROTATE_RIGHT_CARRY = 5'h06,
		OP_SHIFT_RIGHT_ARITHMETIC = 5'h07,
		OP_NIBBLE_SWAP = 5'h08,
		OP_INDEXED_FLAG_SET = 5'h09,
		OP_INDEXED_FLAG_CLEAR = 5'h0a,
		OP_BIT_TO_TRANSFER_FLAG = 5'h0b,
		OP_TRANSFER_FLAG_TO_BIT = 5'h0c,
		OP_REGISTER_COPY = 5'h0d,
		OP_REGISTER_PAIR_COPY = 5'h0e,
		OP_IMMEDIATE_LOAD = 5'h0f,
		OP_POINTER_LOAD = 5'h10,
		OP_POINTER_LOAD_INC = 5'h11,
		OP_POINTER_LOAD_DEC = 5'h12
	} bfme_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EX1 = 2'b01,
		ST_EX2 = 2'b10
	} bfme_state_t;
endpackage : bfme_pkg

// ==== rtl/bfme_regfile.sv ====
// working register file: sixteen 16-bit pairs, two registered read ports
// assumes one writer; byte enables keep the untouched half of a pair
`timescale 1ns/10ps
`default_nettype none
module bfme_regfile #(
	parameter int unsigned DEPTH = 16,
	parameter int unsigned LANES = 2
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic [$clog2(DEPTH)-1:0] i_rd_addr_a,
	input wire logic [$clog2(DEPTH)-1:0] i_rd_addr_b,
	output logic [8*LANES-1:0] o_rd_data_a,
	output logic [8*LANES-1:0] o_rd_data_b,
	input wire logic i_wr_en,
	input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
	input wire logic [8*LANES-1:0] i_wr_data,
	input wire logic [LANES-1:0] i_wr_be
);
	logic [8*LANES-1:0] mem [DEPTH];

	generate
		if (DEPTH < 2 || LANES < 1) begin : g_bad
			$error("bfme_regfile: unsupported geometry");
		end
	endgenerate

	// one writing process keeps the array single-driven across lanes
	always_ff @(posedge i_clock) begin
		if (i_wr_en) begin
			for (int l = 0; l < LANES; l++) begin
				if (i_wr_be[l]) begin
					mem[i_wr_addr][8*l +: 8] <= i_wr_data[8*l +: 8];
				end
			end
		end
	end

	// read returns the old word on a same-cycle write
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_rd_data_a <= '0;
			o_rd_data_b <= '0;
		end else begin
			o_rd_data_a <= mem[i_rd_addr_a];
			o_rd_data_b <= mem[i_rd_addr_b];
		end
	end
endmodule : bfme_regfile
`default_nettype wire

// ==== rtl/bfme_exec.sv ====
// bit, flag and move executor with an apb register front end
// assumes memory data arrives one clock after o_mem_rd, on the same clock
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module bfme_exec import bfme_pkg::*; #(
	parameter int unsigned MEM_AW = 16
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [MEM_AW-1:0] o_mem_addr,
	output logic o_mem_io,
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic [7:0] o_mem_wdata,
	input wire logic [7:0] i_mem_rdata,
	output logic o_busy
);
	generate
		if (MEM_AW < 8 || MEM_AW > 16) begin : g_bad
			$error("bfme_exec: MEM_AW must be 8..16");
		end
	endgenerate

	function automatic logic [2:0] reg_index(input logic [7:0] a);
		case (a)
			BFME_OFF_CMD: reg_index = 3'h1;
			BFME_OFF_STATUS: reg_index = 3'h2;
			BFME_OFF_FLAGS: reg_index = 3'h3;
			BFME_OFF_RESULT: reg_index = 3'h4;
			default: reg_index = 3'h0;
		endcase
	endfunction : reg_index

	function automatic logic [1:0] op_cycles(input bfme_op_t op);
		case (op)
			OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_POINTER_LOAD,
			OP_POINTER_LOAD_INC, OP_POINTER_LOAD_DEC: op_cycles = BFME_CYC_TWO;
			default: op_cycles = BFME_CYC_ONE;
		endcase
	endfunction : op_cycles

	bfme_state_t state_r, state_nxt;
	logic [31:0] cmd_r, cmd_nxt;
	logic [7:0] flags_r, flags_nxt;
	logic [7:0] result_r, result_nxt;
	logic [31:0] prdata_r, prdata_nxt;

	logic access, setup, issue, flags_wr;
	logic [31:0] cur_cmd;
	bfme_op_t op;
	logic [4:0] rd, rr;
	logic [2:0] bsel;
	logic [7:0] imm, rd_val, rr_val, mask, sh_res;
	logic sh_c;
	logic [15:0] pa, pb, ptr;
	logic [3:0] ra_a, ra_b;
	logic wr_en;
	logic [3:0] wr_addr;
	logic [15:0] wr_data;
	logic [1:0] wr_be;

	assign setup = i_psel && !i_penable;
	assign access = i_psel && i_penable;
	assign issue = access && i_pwrite && state_r == ST_IDLE
		&& reg_index(i_paddr) == 3'h1;
	assign flags_wr = access && i_pwrite && state_r == ST_IDLE
		&& reg_index(i_paddr) == 3'h3;
	assign o_pready = 1'b1;
	// writes that would disturb a running instruction are refused
	assign o_pslverr = access && (reg_index(i_paddr) == 3'h0
		|| (i_pwrite && state_r != ST_IDLE
		&& (reg_index(i_paddr) == 3'h1 || reg_index(i_paddr) == 3'h3)));
	assign o_prdata = prdata_r;
	assign o_busy = state_r != ST_IDLE;

	// operands are read in the issue cycle so execution starts next edge
	assign cur_cmd = issue ? i_pwdata : cmd_r;
	assign op = bfme_op_t'(cur_cmd[BFME_CMD_OP_LSB +: 5]);
	assign rd = cur_cmd[BFME_CMD_RD_LSB +: 5];
	assign rr = cur_cmd[BFME_CMD_RR_LSB +: 5];
	assign bsel = cur_cmd[BFME_CMD_BIT_LSB +: 3];
	assign imm = cur_cmd[BFME_CMD_IMM_LSB +: 8];
	assign ra_a = rd[4:1];
	assign ra_b = (op == OP_POINTER_LOAD || op == OP_POINTER_LOAD_INC
		|| op == OP_POINTER_LOAD_DEC) ? {BFME_PTR_BASE, rr[1:0]} : rr[4:1];

	bfme_regfile #(
		.DEPTH(16),
		.LANES(2)
	) u_regfile (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_rd_addr_a(ra_a),
		.i_rd_addr_b(ra_b),
		.o_rd_data_a(pa),
		.o_rd_data_b(pb),
		.i_wr_en(wr_en),
		.i_wr_addr(wr_addr),
		.i_wr_data(wr_data),
		.i_wr_be(wr_be)
	);

	assign rd_val = rd[0] ? pa[15:8] : pa[7:0];
	assign rr_val = rr[0] ? pb[15:8] : pb[7:0];
	assign mask = 8'h01 << bsel;
	assign ptr = (op == OP_POINTER_LOAD_DEC) ? pb - 16'h0001 : pb;

	always_comb begin
		sh_res = rd_val;
		sh_c = flags_r[BFME_FLAG_C];
		case (op)
			OP_SHIFT_LEFT_LOGICAL: begin
				sh_res = {rd_val[6:0], 1'b0};
				sh_c = rd_val[7];
			end
			OP_SHIFT_RIGHT_LOGICAL: begin
				sh_res = {1'b0, rd_val[7:1]};
				sh_c = rd_val[0];
			end
			OP_ROTATE_LEFT_CARRY: begin
				sh_res = {rd_val[6:0], flags_r[BFME_FLAG_C]};
				sh_c = rd_val[7];
			end
			OP_ROTATE_RIGHT_CARRY: begin
				sh_res = {flags_r[BFME_FLAG_C], rd_val[7:1]};
				sh_c = rd_val[0];
			end
			OP_SHIFT_RIGHT_ARITHMETIC: begin
				sh_res = {rd_val[7], rd_val[7:1]};
				sh_c = rd_val[0];
			end
			default: begin
				sh_res = rd_val;
				sh_c = flags_r[BFME_FLAG_C];
			end
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		cmd_nxt = issue ? i_pwdata : cmd_r;
		flags_nxt = flags_wr ? i_pwdata[7:0] : flags_r;
		result_nxt = result_r;
		wr_en = 1'b0;
		wr_addr = rd[4:1];
		wr_data = 16'h0000;
		wr_be = rd[0] ? 2'b10 : 2'b01;
		o_mem_addr = '0;
		o_mem_io = 1'b0;
		o_mem_rd = 1'b0;
		o_mem_wr = 1'b0;
		o_mem_wdata = 8'h00;
		case (state_r)
			ST_IDLE: begin
				if (issue) begin
					state_nxt = ST_EX1;
				end
			end
			ST_EX1: begin
				state_nxt = (op_cycles(op) == BFME_CYC_TWO) ? ST_EX2 : ST_IDLE;
				case (op)
					OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
						o_mem_io = 1'b1;
						o_mem_rd = 1'b1;
						o_mem_addr = MEM_AW'(imm[4:0]);
					end
					OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
					OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
					OP_SHIFT_RIGHT_ARITHMETIC: begin
						wr_en = 1'b1;
						wr_data = {sh_res, sh_res};
						result_nxt = sh_res;
						flags_nxt[BFME_FLAG_C] = sh_c;
						flags_nxt[BFME_FLAG_N] = sh_res[7];
						flags_nxt[BFME_FLAG_V] = sh_res[7] ^ sh_c;
						flags_nxt[BFME_FLAG_Z] = sh_res == 8'h00;
					end
					OP_NIBBLE_SWAP: begin
						wr_en = 1'b1;
						wr_data = {2{rd_val[3:0], rd_val[7:4]}};
						result_nxt = {rd_val[3:0], rd_val[7:4]};
					end
					OP_INDEXED_FLAG_SET: flags_nxt[bsel] = 1'b1;
					OP_INDEXED_FLAG_CLEAR: flags_nxt[bsel] = 1'b0;
					OP_BIT_TO_TRANSFER_FLAG: begin
						flags_nxt[BFME_FLAG_T] = rd_val[bsel];
					end
					OP_TRANSFER_FLAG_TO_BIT: begin
						wr_en = 1'b1;
						result_nxt = flags_r[BFME_FLAG_T] ? rd_val | mask
							: rd_val & ~mask;
						wr_data = {2{result_nxt}};
					end
					OP_REGISTER_COPY: begin
						wr_en = 1'b1;
						wr_data = {rr_val, rr_val};
						result_nxt = rr_val;
					end
					OP_REGISTER_PAIR_COPY: begin
						wr_en = 1'b1;
						wr_be = 2'b11;
						wr_data = pb;
						result_nxt = pb[7:0];
					end
					OP_IMMEDIATE_LOAD: begin
						wr_en = 1'b1;
						wr_data = {imm, imm};
						result_nxt = imm;
					end
					OP_POINTER_LOAD, OP_POINTER_LOAD_INC, OP_POINTER_LOAD_DEC: begin
						o_mem_rd = 1'b1;
						o_mem_addr = ptr[MEM_AW-1:0];
						// plain load leaves the pointer alone
						wr_en = op != OP_POINTER_LOAD;
						wr_addr = {BFME_PTR_BASE, rr[1:0]};
						wr_be = 2'b11;
						wr_data = (op == OP_POINTER_LOAD_INC) ? pb + 16'h0001
							: ptr;
					end
					default: begin
						state_nxt = ST_IDLE;
					end
				endcase
			end
			ST_EX2: begin
				state_nxt = ST_IDLE;
				if (op == OP_IO_BIT_SET || op == OP_IO_BIT_CLEAR) begin
					o_mem_io = 1'b1;
					o_mem_wr = 1'b1;
					o_mem_addr = MEM_AW'(imm[4:0]);
					o_mem_wdata = (op == OP_IO_BIT_SET) ? i_mem_rdata | mask
						: i_mem_rdata & ~mask;
					result_nxt = o_mem_wdata;
				end else begin
					wr_en = 1'b1;
					wr_data = {i_mem_rdata, i_mem_rdata};
					result_nxt = i_mem_rdata;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_comb begin
		prdata_nxt = prdata_r;
		if (setup) begin
			case (reg_index(i_paddr))
				3'h1: prdata_nxt = cmd_r;
				3'h2: begin
					prdata_nxt = 32'h0000_0000;
					prdata_nxt[BFME_STAT_BUSY] = state_r != ST_IDLE;
					prdata_nxt[BFME_STAT_FLAGS_LSB +: 8] = flags_r;
				end
				3'h3: prdata_nxt = {24'h00_0000, flags_r};
				3'h4: prdata_nxt = {24'h00_0000, result_r};
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			state_r <= ST_IDLE;
			cmd_r <= BFME_CMD_RST;
			flags_r <= BFME_FLAGS_RST;
			result_r <= 8'h00;
			prdata_r <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
			cmd_r <= cmd_nxt;
			flags_r <= flags_nxt;
			result_r <= result_nxt;
			prdata_r <= prdata_nxt;
		end
	end
endmodule : bfme_exec
`default_nettype wire

// ==== bench/bfme_exec_chk.sv ====
// port assertions for the bit, flag and move executor
// assumes a bind onto bfme_exec; one clock domain
`timescale 1ns/10ps
`default_nettype none
module bfme_exec_chk import bfme_pkg::*; #(
	parameter int unsigned MEM_AW = 16
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pslverr,
	input wire logic [MEM_AW-1:0] o_mem_addr,
	input wire logic o_mem_io,
	input wire logic o_mem_rd,
	input wire logic o_mem_wr,
	input wire logic o_busy
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	logic cw, go, one, two, ld;
	assign cw = i_psel && i_penable && i_pwrite && i_paddr == BFME_OFF_CMD;
	assign go = cw && !o_busy;
	assign one = go && i_pwdata[4:0] inside {[5'h03:5'h0f]};
	assign two = go && i_pwdata[4:0] inside {5'h01, 5'h02, [5'h10:5'h12]};
	assign ld = go && i_pwdata[4:0] inside {[5'h10:5'h12]};
	chk_two_cycle: assert property (two |=> o_busy ##1 o_busy ##1 !o_busy)
		else $error("two-cycle op busy length wrong");
	chk_one_cycle: assert property (one |=> o_busy ##1 !o_busy)
		else $error("one-cycle op busy length wrong");
	chk_one_no_mem: assert property (one |=> !o_mem_rd && !o_mem_wr)
		else $error("register op touched memory");
	chk_load_reads: assert property (ld |=> o_mem_rd && !o_mem_io
		##1 !o_mem_rd && !o_mem_wr) else $error("pointer load strobe wrong");
	chk_io_rmw: assert property (o_mem_rd && o_mem_io |=> o_mem_wr
		&& o_mem_io && o_mem_addr == $past(o_mem_addr))
		else $error("io write does not follow io read");
	chk_wr_is_io: assert property (o_mem_wr |-> o_mem_io && $past(o_mem_rd))
		else $error("write strobe outside io op");
	chk_busy_max: assert property ($rose(o_busy) |-> ##[1:2] !o_busy)
		else $error("busy too long");
	chk_busy_refuse: assert property (cw && o_busy |-> o_pslverr)
		else $error("command during busy not refused");
	cover property (one);
	cover property (two);
	cover property (cw && o_busy);
endmodule : bfme_exec_chk
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench: apb driver, memory responder, random operands
// assumes bfme_pkg, bfme_exec and bfme_exec_chk compiled before it
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
$display("Error %0t %h %h", $time, (a), (b)); end end
module testbench import bfme_pkg::*; ;
	logic i_clock = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0000_0000;
	logic [7:0] i_mem_rdata = 8'h00;
	logic [31:0] o_prdata, rd_v;
	logic [15:0] o_mem_addr, p, e;
	logic [7:0] o_mem_wdata, wr_data, fl, v;
	logic o_pready, o_pslverr, o_mem_io, o_mem_rd, o_mem_wr, o_busy, err;
	logic [2:0] b;
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;
	bfme_exec i_bfme_exec (.*);
	always #2 i_clock = ~i_clock;
	function automatic logic [7:0] memf(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction : memf
	function automatic logic [31:0] cmd(input logic [4:0] op, rd, rr,
		input logic [2:0] bi, input logic [7:0] k);
		return {6'h00, k, bi, rr, rd, op};
	endfunction : cmd
	function automatic logic [15:0] shx(input logic [4:0] op,
		input logic [7:0] x, f);
		logic [8:0] r;
		case (op)
			5'h03: r = {x, 1'b0};
			5'h04: r = {x[0], 1'b0, x[7:1]};
			5'h05: r = {x, f[0]};
			5'h06: r = {x[0], f[0], x[7:1]};
			5'h07: r = {x[0], x[7], x[7:1]};
			default: return {f, x[3:0], x[7:4]};
		endcase
		return {f[7:4], r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8], r[7:0]};
	endfunction : shx
	// unstrobed cycles return inverted data so a stale byte cannot pass
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		i_mem_rdata <= o_mem_rd ? memf(o_mem_addr) : ~i_mem_rdata;
		if (o_mem_wr) wr_data <= o_mem_wdata;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'b1;
		do @(posedge i_clock); while (o_pready !== 1'b1);
		rd_v = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	// two writes with no idle cycle, so the second lands while busy
	task automatic apb2(input logic [7:0] a, input logic [31:0] d0, d1);
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= 1'b1;
		i_paddr <= a;
		i_pwdata <= d0;
		@(posedge i_clock);
		i_penable <= 1'b1;
		do @(posedge i_clock); while (o_pready !== 1'b1);
		i_penable <= 1'b0;
		i_pwdata <= d1;
		@(posedge i_clock);
		i_penable <= 1'b1;
		do @(posedge i_clock); while (o_pready !== 1'b1);
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb2
	task automatic run(input logic [31:0] c, input int n);
		int k;
		apb(1'b1, BFME_OFF_CMD, c);
		k = 0;
		@(posedge i_clock);
		while (o_busy === 1'b1 && k < 9) begin
			k++;
			@(posedge i_clock);
		end
		`CHK(k, n)
	endtask : run
	task automatic exp_reg(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rd_v[7:0], x)
	endtask : exp_reg
	task automatic stop_test();
		if (fails == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	initial begin
		fl = 8'($urandom(32'h7d1c));
		repeat (8) @(posedge i_clock);
		i_reset_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0000_0000);
			`CHK(rd_v, 32'h0000_0000)
		end
		apb(1'b0, 8'h10, 32'h0000_0000);
		`CHK({err, rd_v}, 33'h1_0000_0000)
		for (int i = 0; i < 42; i++) begin
			v = (i < 6) ? 8'h80 : 8'($urandom);
			fl = 8'($urandom);
			apb(1'b1, BFME_OFF_FLAGS, {24'h0, fl});
			run(cmd(5'h0f, 5'(i), 5'h00, 3'h0, v), 1);
			run(cmd(5'(3 + i % 6), 5'(i), 5'h00, 3'h0, 8'h00), 1);
			e = shx(5'(3 + i % 6), v, fl);
			exp_reg(BFME_OFF_RESULT, e[7:0]);
			exp_reg(BFME_OFF_FLAGS, e[15:8]);
		end
		for (int i = 0; i < 8; i++) begin
			fl = 8'($urandom);
			v = 8'($urandom);
			b = 3'(i);
			apb(1'b1, BFME_OFF_FLAGS, {24'h0, fl});
			run(cmd(5'h09, 5'h00, 5'h00, b, 8'h00), 1);
			exp_reg(BFME_OFF_FLAGS, fl | (8'h01 << b));
			run(cmd(5'h0a, 5'h00, 5'h00, b, 8'h00), 1);
			exp_reg(BFME_OFF_FLAGS, fl & ~(8'h01 << b));
			run(cmd(5'h0f, 5'h05, 5'h05, 3'h0, v), 1);
			run(cmd(5'h0b, 5'h05, 5'h05, b, 8'h00), 1);
			fl[6] = v[b];
			fl = fl & ~(8'h01 << b);
			fl[6] = v[b];
			exp_reg(BFME_OFF_FLAGS, fl);
			fl[6] = ~v[b];
			apb(1'b1, BFME_OFF_FLAGS, {24'h0, fl});
			run(cmd(5'h0c, 5'h05, 5'h05, b, 8'h00), 1);
			v[b] = fl[6];
			exp_reg(BFME_OFF_RESULT, v);
			run(cmd(5'h01, 5'h00, 5'h00, b, {3'h0, v[4:0]}), 2);
			`CHK(wr_data, memf({11'h0, v[4:0]}) | (8'h01 << b))
			run(cmd(5'h02, 5'h00, 5'h00, b, {3'h0, v[4:0]}), 2);
			`CHK(wr_data, memf({11'h0, v[4:0]}) & ~(8'h01 << b))
			exp_reg(BFME_OFF_FLAGS, fl);
		end
		p = 16'($urandom);
		run(cmd(5'h0f, 5'h02, 5'h00, 3'h0, p[7:0]), 1);
		run(cmd(5'h0f, 5'h03, 5'h00, 3'h0, p[15:8]), 1);
		run(cmd(5'h0d, 5'h07, 5'h02, 3'h0, 8'h00), 1);
		exp_reg(BFME_OFF_RESULT, p[7:0]);
		run(cmd(5'h0e, 5'h1e, 5'h02, 3'h0, 8'h00), 1);
		run(cmd(5'h11, 5'h10, 5'h03, 3'h0, 8'h00), 2);
		exp_reg(BFME_OFF_RESULT, memf(p));
		run(cmd(5'h10, 5'h10, 5'h03, 3'h0, 8'h00), 2);
		exp_reg(BFME_OFF_RESULT, memf(p + 16'h0001));
		run(cmd(5'h12, 5'h10, 5'h03, 3'h0, 8'h00), 2);
		exp_reg(BFME_OFF_RESULT, memf(p));
		apb2(BFME_OFF_CMD, cmd(5'h10, 5'h10, 5'h03, 3'h0, 8'h00),
			cmd(5'h0f, 5'h10, 5'h00, 3'h0, 8'h00));
		`CHK(err, 1'b1)
		repeat (2) @(posedge i_clock);
		exp_reg(BFME_OFF_RESULT, memf(p));
		exp_reg(BFME_OFF_FLAGS, fl);
		stop_test();
	end
endmodule : testbench
bind bfme_exec bfme_exec_chk #(.MEM_AW(MEM_AW)) i_bfme_exec_chk (.*);
`default_nettype wire
